// ==== common/pvp_map.vh ====
// constants for the parallel high-voltage programming port.
// assumes a 100 MHz ref_clk; included by bare name from the design files.
// Notes on behaviour
// - action 00 plus crystal pulse loads an address byte; byte select picks low/high.
// - action 01 plus crystal pulse loads a data byte; byte select picks low/high.
// - action 10 loads the command; action 11 does nothing.
// - command 0x80 selects chip erase, started by the next write pulse.
// - command 0x10 selects flash writing, 0x11 selects eeprom writing.
// - command 0x40 writes fuse bits, 0x20 writes lock bits.
// - command 0x08 reads id and trim bytes, 0x04 reads fuses and locks.
// - write or output-enable strobes run the loaded command; 0x02/0x03 read flash/eeprom.
// - busy/ready is 0 during erase or programming, 1 when ready.
// - first byte select: 0 low byte, 1 high byte; set before the pulse.
// - data bus driven by the device only while output enable is low.
// - entry pins stay unchanged 10 us after high voltage so device latches them.
// - loaded command and address are kept across operations.
// - erase clears flash, eeprom (unless preserve fuse), then locks; fuses kept.
// - busy low after erase starts; no new command until busy returns high.
// - high data byte loaded with select 1; page load latches both into the flash buffer, the low byte only into the eeprom buffer.
// - low address bits pick the word in page, high bits pick the page.
// - pages hold 64 words; bits 5..0 word, bits 13..6 page.
// - high address then write pulse programs the whole buffered page; busy low.
// - command 0x00 is a no-operation ending page programming.
`ifndef PVP_MAP_VH
`define PVP_MAP_VH

`define PVP_CLK_PERIOD_NS   10
`define PVP_SIG_HOLD_NS     10000
`define PVP_SIG_HOLD_CYC    ((`PVP_SIG_HOLD_NS + `PVP_CLK_PERIOD_NS - 1) / `PVP_CLK_PERIOD_NS)

`define PVP_ACT_ADDR        2'h0
`define PVP_ACT_DATA        2'h1
`define PVP_ACT_CMD         2'h2
`define PVP_ACT_IDLE        2'h3

`define PVP_CMD_NOP         8'h00
`define PVP_CMD_ERASE       8'h80
`define PVP_CMD_WR_FUSE     8'h40
`define PVP_CMD_WR_LOCK     8'h20
`define PVP_CMD_WR_FLASH    8'h10
`define PVP_CMD_WR_EE       8'h11
`define PVP_CMD_RD_SIG      8'h08
`define PVP_CMD_RD_FUSE     8'h04
`define PVP_CMD_RD_FLASH    8'h02
`define PVP_CMD_RD_EE       8'h03

`define PVP_FUSE_LO_RST     8'h62
`define PVP_FUSE_HI_RST     8'hd9
`define PVP_FUSE_EXT_RST    8'hff
`define PVP_LOCK_RST        8'hff
`define PVP_FUSE_HI_EEKEEP  3
`define PVP_ERASED_WORD     16'hffff
`define PVP_ERASED_BYTE     8'hff

`endif

// ==== design/pvp_sync.v ====
// two-stage synchroniser for a group of pin inputs.
// assumes the pins are quasi-static around each pulse the programmer gives.
module pvp_sync #(
    parameter W       = 1,
    parameter RST_VAL = 0
) (
    // clock and reset
    input  wire         ref_clk,
    input  wire         rst_n,
    // pins and synchronised copy
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] pin_sync
);
    reg [W-1:0] meta_q;

    // meta_q feeds only the second stage
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q   <= RST_VAL[W-1:0];
            pin_sync <= RST_VAL[W-1:0];
        end else begin
            meta_q   <= pin_in;
            pin_sync <= meta_q;
        end
    end
endmodule // pvp_sync

// ==== design/pvp_mem.v ====
// simple memory: one write port, one read port with registered read data.
// assumes contents are undefined until written; no reset on the array.
module pvp_mem #(
    parameter AW = 6,
    parameter DW = 16
) (
    // clock
    input  wire          ref_clk,
    // write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // read port
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // pvp_mem

// ==== design/pvp_port.v ====
// parallel high-voltage programming port: command/address/data loading,
// page buffers, chip erase, page programming, fuse/lock access and reads.
// assumes all pin inputs are asynchronous to ref_clk and pulses last >= 250 ns.
`include "pvp_map.vh"
module pvp_port #(
    parameter FLASH_AW = 14,
    parameter PAGE_AW  = 6,
    parameter EE_AW    = 10,
    parameter EPAGE_AW = 2,
    parameter FUSE_CYC = 16,
    // identity bytes: values are arbitrary
    parameter [7:0] SIG_BYTE0 = 8'h5a,
    parameter [7:0] SIG_BYTE1 = 8'h3c,
    parameter [7:0] SIG_BYTE2 = 8'h01,
    parameter [7:0] CAL_BYTE  = 8'h80
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst_n,
    // high voltage on the reset pin, and resulting mode
    input  wire       hv_sense,
    output reg        prog_mode_out,
    // control pins from the programmer
    input  wire       crystal_input_pulse,
    input  wire       action_sel_hi,
    input  wire       action_sel_lo,
    input  wire       byte_sel_first,
    input  wire       byte_sel_second,
    input  wire       page_load_strobe,
    input  wire       wr_n,
    input  wire       oe_n,
    // data bus, split into input, output and enable
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output reg        data_oe,
    // status
    output reg        busy_ready_out
);
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_ERASE = 5'h02;
    localparam [4:0] ST_FPROG = 5'h04;
    localparam [4:0] ST_EPROG = 5'h08;
    localparam [4:0] ST_FUSE  = 5'h10;
    localparam integer HOLD_CYC = `PVP_SIG_HOLD_CYC;
    localparam CW = FLASH_AW + 1;

    wire [8:0] ctl_s;
    wire [7:0] data_s;
    wire       xtal_s   = ctl_s[0];
    wire [1:0] act_s    = ctl_s[2:1];
    wire       bsf_s    = ctl_s[3];
    wire       bss_s    = ctl_s[4];
    wire       pload_s  = ctl_s[5];
    wire       wr_n_s   = ctl_s[6];
    wire       oe_n_s   = ctl_s[7];
    wire       hv_s     = ctl_s[8];

    reg         xtal_d1_q;
    reg         pload_d1_q;
    reg         wr_n_d1_q;
    reg         hv_d1_q;
    reg  [10:0] hold_cnt_q;
    reg         hold_run_q;
    reg         prog_q;
    reg  [4:0]  state_q;
    reg  [CW-1:0] cnt_q;
    reg  [7:0]  cmd_q;
    reg  [15:0] addr_q;
    reg  [7:0]  dlo_q;
    reg  [7:0]  dhi_q;
    reg  [7:0]  fuse_lo_q;
    reg  [7:0]  fuse_hi_q;
    reg  [7:0]  fuse_ext_q;
    reg  [7:0]  lock_q;
    reg         fuse_bsf_q;
    reg         fuse_bss_q;
    reg  [7:0]  rd_byte;

    wire [15:0] fl_rd;
    wire [15:0] pb_rd;
    wire [7:0]  ee_rd;
    wire [7:0]  eb_rd;

    pvp_sync #(.W(9), .RST_VAL(9'h0c0)) u_ctl_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .pin_in   ({hv_sense, oe_n, wr_n, page_load_strobe, byte_sel_second,
                    byte_sel_first, action_sel_hi, action_sel_lo, crystal_input_pulse}),
        .pin_sync (ctl_s)
    );

    pvp_sync #(.W(8), .RST_VAL(0)) u_data_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .pin_in   (data_in),
        .pin_sync (data_s)
    );

    wire xtal_rise  = xtal_s & ~xtal_d1_q;
    wire pload_rise = pload_s & ~pload_d1_q;
    wire wr_fall    = ~wr_n_s & wr_n_d1_q;
    wire idle       = state_q == ST_IDLE;
    wire eekeep     = ~fuse_hi_q[`PVP_FUSE_HI_EEKEEP];
    wire [CW-1:0] cnt_m1 = cnt_q - 1'b1;
    wire [CW-1:0] page_end  = {{(CW-1){1'b0}}, 1'b1} << PAGE_AW;
    wire [CW-1:0] epage_end = {{(CW-1){1'b0}}, 1'b1} << EPAGE_AW;
    wire [CW-1:0] flash_end = {{(CW-1){1'b0}}, 1'b1} << FLASH_AW;

    // memory write controls
    wire fl_we = prog_q & ((state_q == ST_ERASE) & ~cnt_q[FLASH_AW] |
                 (state_q == ST_FPROG) & (cnt_q != 0));
    wire [FLASH_AW-1:0] fl_wa = (state_q == ST_ERASE) ? cnt_q[FLASH_AW-1:0] :
                 {addr_q[FLASH_AW-1:PAGE_AW], cnt_m1[PAGE_AW-1:0]};
    wire [15:0] fl_wd = (state_q == ST_ERASE) ? `PVP_ERASED_WORD : pb_rd;

    wire pb_latch = prog_q & idle & pload_rise & (cmd_q == `PVP_CMD_WR_FLASH);
    wire pb_we    = pb_latch | (state_q == ST_FPROG) & (cnt_q != 0);
    wire [PAGE_AW-1:0] pb_wa = pb_latch ? addr_q[PAGE_AW-1:0] : cnt_m1[PAGE_AW-1:0];
    wire [15:0] pb_wd = pb_latch ? {dhi_q, dlo_q} : `PVP_ERASED_WORD;

    wire ee_erase = (state_q == ST_ERASE) & (cnt_q < (1 << EE_AW)) & ~eekeep;
    wire ee_we    = prog_q & (ee_erase | (state_q == ST_EPROG) & (cnt_q != 0));
    wire [EE_AW-1:0] ee_wa = ee_erase ? cnt_q[EE_AW-1:0] :
                 {addr_q[EE_AW-1:EPAGE_AW], cnt_m1[EPAGE_AW-1:0]};
    wire [7:0] ee_wd = ee_erase ? `PVP_ERASED_BYTE : eb_rd;

    wire eb_latch = prog_q & idle & pload_rise & (cmd_q == `PVP_CMD_WR_EE);
    wire eb_we    = eb_latch | (state_q == ST_EPROG) & (cnt_q != 0);
    wire [EPAGE_AW-1:0] eb_wa = eb_latch ? addr_q[EPAGE_AW-1:0] : cnt_m1[EPAGE_AW-1:0];
    wire [7:0] eb_wd = eb_latch ? dlo_q : `PVP_ERASED_BYTE;

    pvp_mem #(.AW(FLASH_AW), .DW(16)) u_flash (
        .ref_clk (ref_clk),
        .wr_en   (fl_we),
        .wr_addr (fl_wa),
        .wr_data (fl_wd),
        .rd_addr (addr_q[FLASH_AW-1:0]),
        .rd_data (fl_rd)
    );

    pvp_mem #(.AW(PAGE_AW), .DW(16)) u_page_buf (
        .ref_clk (ref_clk),
        .wr_en   (pb_we),
        .wr_addr (pb_wa),
        .wr_data (pb_wd),
        .rd_addr (cnt_q[PAGE_AW-1:0]),
        .rd_data (pb_rd)
    );

    pvp_mem #(.AW(EE_AW), .DW(8)) u_eeprom (
        .ref_clk (ref_clk),
        .wr_en   (ee_we),
        .wr_addr (ee_wa),
        .wr_data (ee_wd),
        .rd_addr (addr_q[EE_AW-1:0]),
        .rd_data (ee_rd)
    );

    pvp_mem #(.AW(EPAGE_AW), .DW(8)) u_ee_buf (
        .ref_clk (ref_clk),
        .wr_en   (eb_we),
        .wr_addr (eb_wa),
        .wr_data (eb_wd),
        .rd_addr (cnt_q[EPAGE_AW-1:0]),
        .rd_data (eb_rd)
    );

    // edge history and programming mode entry
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            xtal_d1_q  <= 1'b0;
            pload_d1_q <= 1'b0;
            wr_n_d1_q  <= 1'b1;
            hv_d1_q    <= 1'b0;
            hold_cnt_q <= 11'h000;
            hold_run_q <= 1'b0;
            prog_q     <= 1'b0;
        end else begin
            xtal_d1_q  <= xtal_s;
            pload_d1_q <= pload_s;
            wr_n_d1_q  <= wr_n_s;
            hv_d1_q    <= hv_s;
            if (!hv_s) begin
                hold_run_q <= 1'b0;
                hold_cnt_q <= 11'h000;
                prog_q     <= 1'b0;
            end else if (!hv_d1_q) begin
                hold_run_q <= 1'b1;
                hold_cnt_q <= 11'h000;
            end else if (hold_run_q) begin
                hold_cnt_q <= hold_cnt_q + 11'h001;
                // signature sampled once the hold time has elapsed
                if (hold_cnt_q == HOLD_CYC[10:0] - 11'h001) begin
                    hold_run_q <= 1'b0;
                    prog_q     <= ~(pload_s | act_s[1] | act_s[0] | bsf_s);
                end
            end
        end
    end

    // loads, operation sequencing and nonvolatile registers
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            cnt_q      <= {CW{1'b0}};
            cmd_q      <= `PVP_CMD_NOP;
            addr_q     <= 16'h0000;
            dlo_q      <= 8'h00;
            dhi_q      <= 8'h00;
            fuse_lo_q  <= `PVP_FUSE_LO_RST;
            fuse_hi_q  <= `PVP_FUSE_HI_RST;
            fuse_ext_q <= `PVP_FUSE_EXT_RST;
            lock_q     <= `PVP_LOCK_RST;
            fuse_bsf_q <= 1'b0;
            fuse_bss_q <= 1'b0;
        end else if (!prog_q) begin
            state_q <= ST_IDLE;
            cnt_q   <= {CW{1'b0}};
            cmd_q   <= `PVP_CMD_NOP;
        end else begin
            case (state_q)
            ST_IDLE: begin
                cnt_q <= {CW{1'b0}};
                // loads are refused while an operation runs, so only here
                if (xtal_rise) begin
                    case (act_s)
                    `PVP_ACT_ADDR: begin
                        if (bsf_s) addr_q[15:8] <= data_s;
                        else       addr_q[7:0]  <= data_s;
                    end
                    `PVP_ACT_DATA: begin
                        if (bsf_s) dhi_q <= data_s;
                        else       dlo_q <= data_s;
                    end
                    `PVP_ACT_CMD: cmd_q <= data_s;
                    default: ;
                    endcase
                end else if (wr_fall) begin
                    case (cmd_q)
                    `PVP_CMD_ERASE:    state_q <= ST_ERASE;
                    `PVP_CMD_WR_FLASH: state_q <= ST_FPROG;
                    `PVP_CMD_WR_EE:    state_q <= ST_EPROG;
                    `PVP_CMD_WR_FUSE, `PVP_CMD_WR_LOCK: begin
                        state_q    <= ST_FUSE;
                        fuse_bsf_q <= bsf_s;
                        fuse_bss_q <= bss_s;
                    end
                    default: ;
                    endcase
                end
            end
            ST_ERASE: begin
                cnt_q <= cnt_q + 1'b1;
                // locks cleared only after the whole flash is erased
                if (cnt_q == flash_end) begin
                    lock_q  <= `PVP_LOCK_RST;
                    state_q <= ST_IDLE;
                end
            end
            ST_FPROG: begin
                cnt_q <= cnt_q + 1'b1;
                if (cnt_q == page_end) state_q <= ST_IDLE;
            end
            ST_EPROG: begin
                cnt_q <= cnt_q + 1'b1;
                if (cnt_q == epage_end) state_q <= ST_IDLE;
            end
            ST_FUSE: begin
                cnt_q <= cnt_q + 1'b1;
                if (cnt_q == FUSE_CYC[CW-1:0]) begin
                    state_q <= ST_IDLE;
                    if (cmd_q == `PVP_CMD_WR_LOCK) begin
                        lock_q <= lock_q & dlo_q;
                    end else if (fuse_bss_q) begin
                        fuse_ext_q <= dlo_q;
                    end else if (fuse_bsf_q) begin
                        fuse_hi_q <= dlo_q;
                    end else begin
                        fuse_lo_q <= dlo_q;
                    end
                end
            end
            default: state_q <= ST_IDLE;
            endcase
        end
    end

    // read data selection by loaded command and byte selects
    always @* begin
        rd_byte = 8'h00;
        case (cmd_q)
        `PVP_CMD_RD_FLASH: rd_byte = bsf_s ? fl_rd[15:8] : fl_rd[7:0];
        `PVP_CMD_RD_EE:    rd_byte = ee_rd;
        `PVP_CMD_RD_SIG: begin
            if (bsf_s) begin
                rd_byte = CAL_BYTE;
            end else begin
                case (addr_q[1:0])
                2'h0:    rd_byte = SIG_BYTE0;
                2'h1:    rd_byte = SIG_BYTE1;
                2'h2:    rd_byte = SIG_BYTE2;
                default: rd_byte = 8'h00;
                endcase
            end
        end
        `PVP_CMD_RD_FUSE: begin
            case ({bss_s, bsf_s})
            2'h0:    rd_byte = fuse_lo_q;
            2'h3:    rd_byte = fuse_hi_q;
            2'h2:    rd_byte = fuse_ext_q;
            default: rd_byte = lock_q;
            endcase
        end
        default: rd_byte = 8'h00;
        endcase
    end

    // pin outputs
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            data_out       <= 8'h00;
            data_oe        <= 1'b0;
            busy_ready_out <= 1'b1;
            prog_mode_out  <= 1'b0;
        end else begin
            data_out       <= rd_byte;
            data_oe        <= prog_q & ~oe_n_s;
            busy_ready_out <= ~prog_q | (idle & ~(wr_fall & ~xtal_rise &
                              ((cmd_q == `PVP_CMD_ERASE) | (cmd_q == `PVP_CMD_WR_FLASH) |
                               (cmd_q == `PVP_CMD_WR_EE) | (cmd_q == `PVP_CMD_WR_FUSE) |
                               (cmd_q == `PVP_CMD_WR_LOCK))));
            prog_mode_out  <= prog_q;
        end
    end
endmodule // pvp_port

// ==== bench/pvp_port_chk.sv ====
// checker: pin-level timing relations of the programming port.
// assumes it is bound to pvp_port; pins change between ref_clk edges.
module pvp_port_chk (
    // clock and reset
    input wire       ref_clk,
    input wire       rst_n,
    // programmer pins
    input wire       hv_sense,
    input wire       crystal_input_pulse,
    input wire       action_sel_hi,
    input wire       action_sel_lo,
    input wire       byte_sel_first,
    input wire       page_load_strobe,
    input wire       wr_n,
    input wire       oe_n,
    input wire [7:0] data_in,
    // port outputs
    input wire       prog_mode_out,
    input wire       data_oe,
    input wire       busy_ready_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  cmd_q;
    logic [10:0] hv_q;
    logic [14:0] low_q;
    wire         is_wr = cmd_q inside {8'h80, 8'h40, 8'h20, 8'h10, 8'h11};

    // command shadow taken at the raw pin edge; data is held around it
    always @(posedge ref_clk) begin
        if (!rst_n || !prog_mode_out) begin
            cmd_q <= 8'h00;
        end else if ($rose(crystal_input_pulse) && busy_ready_out
                     && {action_sel_hi, action_sel_lo} == 2'h2) begin
            cmd_q <= data_in;
        end
        if (!rst_n || !hv_sense) hv_q <= 11'h000;
        else if (hv_q != 11'h7ff) hv_q <= hv_q + 11'h001;
        if (!rst_n || busy_ready_out) low_q <= 15'h0000;
        else if (low_q != 15'h7fff) low_q <= low_q + 15'h0001;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_OE_IN_MODE: assert property (data_oe |-> prog_mode_out || $past(prog_mode_out))
        else $error("data bus driven outside programming mode");
    AST_OE_ON: assert property ((prog_mode_out && !oe_n) [*5] |-> data_oe)
        else $error("data bus not driven while output enable low");
    AST_OE_OFF: assert property (oe_n [*5] |-> !data_oe)
        else $error("data bus driven while output enable high");
    AST_READY_IDLE: assert property (!prog_mode_out |-> busy_ready_out)
        else $error("busy outside programming mode");
    AST_WR_BUSY: assert property ($fell(wr_n) && prog_mode_out && busy_ready_out && is_wr
        |-> ##[2:5] !busy_ready_out) else $error("write pulse did not start operation");
    AST_NOP_IDLE: assert property ($fell(wr_n) && busy_ready_out && !is_wr
        |-> busy_ready_out [*8]) else $error("write pulse acted without a write command");
    AST_BUSY_MIN: assert property ($fell(busy_ready_out) |-> !busy_ready_out [*4])
        else $error("busy pulse too short");
    AST_BUSY_MAX: assert property (low_q <= 15'h4010)
        else $error("busy held too long");
    AST_ENTRY_PINS: assert property ($rose(prog_mode_out) |-> !page_load_strobe
        && !action_sel_hi && !action_sel_lo && !byte_sel_first)
        else $error("entered mode with wrong signature");
    AST_ENTRY_WAIT: assert property ($rose(prog_mode_out) |-> hv_q >= 11'h3e8)
        else $error("entered mode before signature hold time");

    cover property ($rose(prog_mode_out));
    cover property ($fell(busy_ready_out) ##1 !busy_ready_out [*8]);
    cover property (data_oe ##1 !data_oe);
endmodule // pvp_port_chk

bind pvp_port pvp_port_chk u_chk (
    .ref_clk, .rst_n, .hv_sense, .crystal_input_pulse, .action_sel_hi, .action_sel_lo,
    .byte_sel_first, .page_load_strobe, .wr_n, .oe_n, .data_in, .prog_mode_out,
    .data_oe, .busy_ready_out);

// ==== bench/pvp_prog.sv ====
// programmer model: drives the strobes, selects and data bus of the port.
// assumes a 100 MHz ref_clk; every strobe, select and driven data change lands 1 ns after a rising edge.
module pvp_prog (
    // clock
    input  wire        ref_clk,
    // port status
    input  wire        busy_ready_out,
    input  wire  [7:0] data_out,
    input  wire        data_oe,
    // strobes and selects
    output logic       hv_sense,
    output logic       crystal_input_pulse,
    output logic       action_sel_hi,
    output logic       action_sel_lo,
    output logic       byte_sel_first,
    output logic       byte_sel_second,
    output logic       page_load_strobe,
    output logic       wr_n,
    output logic       oe_n,
    // resolved data bus
    output wire  [7:0] data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PW = 26; // 260 ns crystal and page load strobes and a 270 ns write strobe stay above their minimum
    logic       drv_en;
    logic [7:0] drv_val;
    logic [7:0] last_q = 8'h00;

    // a released bus toggles, so a stale value never reads as valid
    assign data_in = data_oe ? data_out : drv_en ? drv_val : ~last_q;
    always @(posedge ref_clk) last_q <= data_in;

    initial begin
        {hv_sense, crystal_input_pulse, action_sel_hi, action_sel_lo} = 4'h0;
        {byte_sel_first, byte_sel_second, page_load_strobe} = 3'h0;
        {wr_n, oe_n, drv_en} = 3'h7;
        drv_val = 8'h00;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic enter;
        hv_sense = 1'b1;
        step(1010);
        step(29000);
    endtask

    task automatic load(input logic [1:0] act, input logic bsf, input logic [7:0] val);
        {action_sel_hi, action_sel_lo} = act;
        byte_sel_first = bsf;
        drv_en = 1'b1;
        drv_val = val;
        step(4);
        crystal_input_pulse = 1'b1;
        step(PW);
        crystal_input_pulse = 1'b0;
        step(4);
    endtask

    task automatic latch;
        byte_sel_first = 1'b1;
        step(4);
        page_load_strobe = 1'b1;
        step(PW);
        page_load_strobe = 1'b0;
        step(4);
    endtask

    task automatic wr_op(input logic bss, input logic bsf, output int low);
        byte_sel_second = bss;
        byte_sel_first = bsf;
        step(4);
        low = 0;
        wr_n = 1'b0;
        for (int i = 0; i < 20000; i++) begin
            step(1);
            if (i == PW) wr_n = 1'b1;
            if (busy_ready_out !== 1'b1) low++;
            else if (i > PW) break;
        end
    endtask

    task automatic read_bus(input logic bss, input logic bsf, output logic [7:0] val);
        byte_sel_second = bss;
        byte_sel_first = bsf;
        drv_en = 1'b0;
        oe_n = 1'b0;
        step(8);
        val = data_in;
        oe_n = 1'b1;
        step(5);
    endtask
endmodule // pvp_prog

// ==== bench/pvp_port_tb.sv ====
// testbench: entry, identity and fuse reads, page writes, no-op and erase.
// assumes pvp_prog drives the pins and pvp_port_chk is bound to the port.
`include "pvp_map.vh"
module pvp_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // identity bytes: values are arbitrary
    localparam logic [7:0] SIG [3] = '{8'h4b, 8'h2d, 8'h07};
    localparam logic [7:0] CAL = 8'h91;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    wire         hv, xtal, a_hi, a_lo, bsf, bss, pload, wr_n, oe_n, mode, oe, rdy;
    wire  [7:0]  din, dout;
    int          errors = 0;
    int          compares = 0;
    int          low;
    integer      seed = 32'h9728;
    logic [7:0]  v, pg, ep;
    logic [7:0]  fz [4] = '{8'h62, 8'hff, 8'hff, 8'hd9};
    logic [15:0] flash_m [64];
    logic [7:0]  ee_m [4];

    always #5 ref_clk = ~ref_clk;

    pvp_port #(.SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]), .CAL_BYTE(CAL)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .hv_sense(hv), .prog_mode_out(mode),
        .crystal_input_pulse(xtal), .action_sel_hi(a_hi), .action_sel_lo(a_lo),
        .byte_sel_first(bsf), .byte_sel_second(bss), .page_load_strobe(pload), .wr_n(wr_n),
        .oe_n(oe_n), .data_in(din), .data_out(dout), .data_oe(oe), .busy_ready_out(rdy));
    pvp_prog prog (
        .ref_clk(ref_clk), .busy_ready_out(rdy), .data_out(dout), .data_oe(oe), .hv_sense(hv),
        .crystal_input_pulse(xtal), .action_sel_hi(a_hi), .action_sel_lo(a_lo),
        .byte_sel_first(bsf), .byte_sel_second(bss), .page_load_strobe(pload), .wr_n(wr_n),
        .oe_n(oe_n), .data_in(din));

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        prog.load(`PVP_ACT_CMD, 1'b0, c);
    endtask
    task automatic rd(input logic [1:0] bs, input logic [7:0] exp);
        logic [7:0] got;
        prog.read_bus(bs[1], bs[0], got);
        chk_byte(got, exp);
    endtask
    task automatic wr_chk(input logic [1:0] bs, input logic exp);
        prog.wr_op(bs[1], bs[0], low);
        chk_flag(low > 0, exp);
    endtask
    task automatic rd_fuses;
        cmd(`PVP_CMD_RD_FUSE);
        for (int k = 0; k < 4; k++) rd(k[1:0], fz[k]);
    endtask
    task automatic rd_flash;
        cmd(`PVP_CMD_RD_FLASH);
        prog.load(`PVP_ACT_ADDR, 1'b1, {2'h0, pg[7:2]});
        for (int w = 0; w < 64; w++) begin
            prog.load(`PVP_ACT_ADDR, 1'b0, {pg[1:0], w[5:0]});
            rd(2'h0, flash_m[w][7:0]);
            rd(2'h1, flash_m[w][15:8]);
        end
    endtask
    task automatic rd_ee;
        cmd(`PVP_CMD_RD_EE);
        prog.load(`PVP_ACT_ADDR, 1'b1, {6'h00, ep[7:6]});
        for (int b = 0; b < 4; b++) begin
            prog.load(`PVP_ACT_ADDR, 1'b0, {ep[5:0], b[1:0]});
            rd(2'h0, ee_m[b]);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge ref_clk);
        errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        chk_flag(rdy, 1'b1);
        chk_flag(oe, 1'b0);
        prog.enter();
        chk_flag(mode, 1'b1);
        cmd(`PVP_CMD_RD_SIG);
        for (int i = 0; i < 3; i++) begin
            prog.load(`PVP_ACT_ADDR, 1'b0, i[7:0]);
            rd(2'h0, SIG[i]);
        end
        prog.load(`PVP_ACT_ADDR, 1'b0, 8'h00);
        rd(2'h1, CAL);
        rd_fuses();
        cmd(`PVP_CMD_WR_FUSE);
        for (int k = 0; k < 3; k++) begin
            v = 8'($random(seed));
            if (k == 1) v[3] = 1'b0; // programmed preserve bit keeps eeprom through erase
            prog.load(`PVP_ACT_DATA, 1'b0, v);
            wr_chk(k[1:0], 1'b1);
            fz[k == 1 ? 3 : k] = v;
        end
        cmd(`PVP_CMD_WR_LOCK);
        v = 8'($random(seed));
        prog.load(`PVP_ACT_DATA, 1'b0, v);
        wr_chk(2'h0, 1'b1);
        fz[1] = fz[1] & v;
        rd_fuses();
        pg = 8'($random(seed));
        cmd(`PVP_CMD_WR_FLASH);
        for (int w = 0; w < 64; w++) begin
            flash_m[w] = 16'($random(seed));
            prog.load(`PVP_ACT_ADDR, 1'b0, {pg[1:0], w[5:0]});
            prog.load(`PVP_ACT_DATA, 1'b0, flash_m[w][7:0]);
            prog.load(`PVP_ACT_DATA, 1'b1, flash_m[w][15:8]);
            prog.latch();
        end
        prog.load(`PVP_ACT_ADDR, 1'b1, {2'h0, pg[7:2]});
        wr_chk(2'h1, 1'b1);
        rd_flash();
        prog.load(`PVP_ACT_ADDR, 1'b0, {pg[1:0], 6'h07});
        prog.load(`PVP_ACT_IDLE, 1'b0, 8'h00);
        rd(2'h0, flash_m[7][7:0]);
        ep = 8'($random(seed));
        cmd(`PVP_CMD_WR_EE);
        prog.load(`PVP_ACT_ADDR, 1'b1, {6'h00, ep[7:6]});
        for (int b = 0; b < 4; b++) begin
            ee_m[b] = 8'($random(seed));
            prog.load(`PVP_ACT_ADDR, 1'b0, {ep[5:0], b[1:0]});
            prog.load(`PVP_ACT_DATA, 1'b0, ee_m[b]);
            prog.latch();
        end
        wr_chk(2'h0, 1'b1);
        rd_ee();
        cmd(`PVP_CMD_NOP);
        wr_chk(2'h0, 1'b0);
        cmd(`PVP_CMD_ERASE);
        wr_chk(2'h0, 1'b1);
        chk_flag(low > 16000, 1'b1);
        fz[1] = 8'hff;
        rd_fuses();
        foreach (flash_m[w]) flash_m[w] = 16'hffff;
        rd_flash();
        rd_ee();
        tally_and_finish();
    end
endmodule // pvp_port_tb
